//--- common/area_wait_defines.svh
// Register offsets, field positions, reset values and timing counts
// for the area wait-state controller. Definitions only.
`ifndef AREA_WAIT_DEFINES_SVH
`define AREA_WAIT_DEFINES_SVH

// APB byte offsets of the register words
`define BUS_CONTROL_OFFSET   8'h00
`define WAIT_CONTROL_OFFSET  8'h04
`define STATUS_OFFSET        8'h08

// Bus control: memory type field
`define MEM_TYPE_POS         12
`define MEM_TYPE_RESET       4'h0
`define MEM_TYPE_NORMAL      4'h0
`define MEM_TYPE_BYTE_SRAM   4'h3

// Wait control field positions
`define SETUP_DELAY_POS      11
`define ACCESS_WAIT_POS      7
`define EXT_WAIT_MASK_POS    6
`define HOLD_DELAY_POS       0

// Wait control reset values
`define SETUP_DELAY_RESET    2'h0
`define ACCESS_WAIT_RESET    4'hA
`define EXT_WAIT_MASK_RESET  1'h0
`define HOLD_DELAY_RESET     2'h0

// Reference clock cycles per bus cycle (half a bus cycle is one tick)
`define TICKS_PER_BUS_CYCLE  7'h02

`endif

//--- common/area_wait_pkg.sv
// Types shared by the area wait-state controller and its decoder.
// Assumes the constants header is compiled alongside.
package area_wait_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } access_state_t;

  typedef struct packed {
    logic [1:0] setup_delay;
    logic [3:0] access_wait;
    logic       external_wait_mask;
    logic [1:0] hold_delay;
  } wait_fields_t;

  typedef struct packed {
    logic        write;
    logic [1:0]  lanes;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

endpackage

//--- hw/area_wait_ctrl.sv
// Wait-state timing for one external memory area behind an APB slave.
// Assumes ref_clk at 40 MHz is twice the bus clock and inputs are synchronous.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "area_wait_defines.svh"

//  Contract
// - Wait layout follows selected memory type
// - Setup delay 0.5 to 3.5 cycles
// - Wait code gives 0..6,8,10,12,14,18,24 cycles
// - Wait resets to 1010, others zero
// - Mask zero honours external wait, one ignores
// - Mask applies even with zero waits
// - Hold delay 0.5 to 3.5 cycles
// - Reserved bits read zero, written zero
// - Types 0000 and 0011 use this layout
module area_wait_ctrl (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    mem_req_valid,
  input  wire area_wait_pkg::mem_req_t mem_req,
  output logic                         mem_req_ready,
  output logic                         mem_done,
  output logic                         mem_error,
  output logic      [15:0]             mem_rdata,
  output logic      [15:0]             mem_addr,
  output logic                         chip_select_n,
  output logic                         read_n,
  output logic      [1:0]              byte_enable_n,
  output logic      [15:0]             data_out,
  output logic                         data_oe_n,
  input  wire logic [15:0]             data_in,
  input  wire logic                    external_wait_n
);

  logic [3:0]                  memory_type;
  area_wait_pkg::wait_fields_t wait_fields;
  area_wait_pkg::wait_fields_t cur_fields;
  area_wait_pkg::access_state_t state;
  area_wait_pkg::mem_req_t     cur_req;
  logic [6:0]                  cnt;
  logic [6:0]                  setup_len;
  logic [6:0]                  strobe_len;
  logic [6:0]                  hold_len;
  logic                        type_ok;
  logic                        apb_write;
  logic                        wait_honoured;
  logic [31:0]                 next_prdata;
  logic                        next_pslverr;

  // Decoder sees the fields latched for the current access
  wait_timing_decode u_decode (
    .fields     (cur_fields),
    .setup_len  (setup_len),
    .strobe_len (strobe_len),
    .hold_len   (hold_len)
  );

  // Only the two asynchronous layouts are timed here
  assign type_ok = (memory_type == `MEM_TYPE_NORMAL) ||
                   (memory_type == `MEM_TYPE_BYTE_SRAM);
  assign apb_write     = psel && penable && pready && pwrite;
  assign wait_honoured = !cur_fields.external_wait_mask && !external_wait_n;

  // Read mux and unmapped-address answer
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == `BUS_CONTROL_OFFSET) begin
      next_prdata[`MEM_TYPE_POS +: 4] = memory_type;
    end else if (paddr == `WAIT_CONTROL_OFFSET) begin
      // Reserved positions stay at the zero default
      next_prdata[`SETUP_DELAY_POS +: 2] = wait_fields.setup_delay;
      next_prdata[`ACCESS_WAIT_POS +: 4] = wait_fields.access_wait;
      next_prdata[`EXT_WAIT_MASK_POS]    = wait_fields.external_wait_mask;
      next_prdata[`HOLD_DELAY_POS +: 2]  = wait_fields.hold_delay;
    end else if (paddr == `STATUS_OFFSET) begin
      next_prdata[0] = (state != area_wait_pkg::ST_IDLE);
      next_prdata[1] = mem_error;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // APB answer: pready one cycle into the access phase
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && next_pslverr;
      prdata  <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Register writes; software orders type before timing
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memory_type                    <= `MEM_TYPE_RESET;
      wait_fields.setup_delay        <= `SETUP_DELAY_RESET;
      wait_fields.access_wait        <= `ACCESS_WAIT_RESET;
      wait_fields.external_wait_mask <= `EXT_WAIT_MASK_RESET;
      wait_fields.hold_delay         <= `HOLD_DELAY_RESET;
    end else if (clk_en && apb_write) begin
      if (paddr == `BUS_CONTROL_OFFSET) begin
        memory_type <= pwdata[`MEM_TYPE_POS +: 4];
      end else if (paddr == `WAIT_CONTROL_OFFSET) begin
        wait_fields.setup_delay        <= pwdata[`SETUP_DELAY_POS +: 2];
        wait_fields.access_wait        <= pwdata[`ACCESS_WAIT_POS +: 4];
        wait_fields.external_wait_mask <= pwdata[`EXT_WAIT_MASK_POS];
        wait_fields.hold_delay         <= pwdata[`HOLD_DELAY_POS +: 2];
      end
    end
  end

  // Access sequencer: setup, strobe, hold, all in half bus cycles
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state         <= area_wait_pkg::ST_IDLE;
      cnt           <= 7'h00;
      cur_req       <= '0;
      cur_fields    <= '0;
      mem_req_ready <= 1'b0;
      mem_done      <= 1'b0;
      mem_error     <= 1'b0;
      mem_rdata     <= 16'h0000;
      mem_addr      <= 16'h0000;
      chip_select_n <= 1'b1;
      read_n        <= 1'b1;
      byte_enable_n <= 2'h3;
      data_out      <= 16'h0000;
      data_oe_n     <= 1'b1;
    end else if (clk_en) begin
      mem_done <= 1'b0;
      case (state)
        area_wait_pkg::ST_IDLE: begin
          mem_req_ready <= 1'b1;
          if (mem_req_valid && mem_req_ready) begin
            if (!type_ok) begin
              // Other memory types are not timed by this block
              mem_done  <= 1'b1;
              mem_error <= 1'b1;
            end else begin
              // Fields are frozen for the whole access
              mem_req_ready <= 1'b0;
              cur_req       <= mem_req;
              cur_fields    <= wait_fields;
              mem_addr      <= mem_req.addr;
              chip_select_n <= 1'b0;
              data_out      <= mem_req.wdata;
              data_oe_n     <= !mem_req.write;
              cnt           <= {4'h0, wait_fields.setup_delay, 1'b0};
              state         <= area_wait_pkg::ST_SETUP;
            end
          end
        end
        area_wait_pkg::ST_SETUP: begin
          if (cnt == 7'h00) begin
            read_n <= cur_req.write;
            // Byte-select SRAM strobes lanes on reads too
            if (cur_req.write || memory_type == `MEM_TYPE_BYTE_SRAM) begin
              byte_enable_n <= ~cur_req.lanes;
            end
            cnt   <= 7'(strobe_len - 7'h01);
            state <= area_wait_pkg::ST_STROBE;
          end else begin
            cnt <= 7'(cnt - 7'h01);
          end
        end
        area_wait_pkg::ST_STROBE: begin
          if (cnt != 7'h00) begin
            cnt <= 7'(cnt - 7'h01);
          end else if (!wait_honoured) begin
            // A honoured wait keeps the strobe; otherwise close it
            read_n        <= 1'b1;
            byte_enable_n <= 2'h3;
            mem_rdata     <= cur_req.write ? mem_rdata : data_in;
            cnt           <= 7'(hold_len - 7'h01);
            state         <= area_wait_pkg::ST_HOLD;
          end
        end
        area_wait_pkg::ST_HOLD: begin
          if (cnt == 7'h00) begin
            chip_select_n <= 1'b1;
            data_oe_n     <= 1'b1;
            mem_done      <= 1'b1;
            mem_error     <= 1'b0;
            mem_req_ready <= 1'b1;
            state         <= area_wait_pkg::ST_IDLE;
          end else begin
            cnt <= 7'(cnt - 7'h01);
          end
        end
        default: state <= area_wait_pkg::ST_IDLE;
      endcase
    end
  end

  // Phase-length helper: during a tick it holds the length of the run that
  // ended on the previous tick, so a phase is complete when its end is sampled
  logic       strobe_on;
  logic [1:0] phase_key;
  logic [1:0] prev_key;
  logic [7:0] phase_len;
  assign strobe_on = !read_n || (byte_enable_n != 2'h3);
  assign phase_key = {chip_select_n, strobe_on};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_key  <= 2'h2;
      phase_len <= 8'h00;
    end else if (clk_en) begin
      prev_key  <= phase_key;
      phase_len <= (phase_key != prev_key) ? 8'h01 : 8'(phase_len + 8'h01);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_WAIT_RESET: assert property ($rose(rst_n) |-> wait_fields.access_wait == 4'hA &&
    wait_fields.setup_delay == 2'h0 && !wait_fields.external_wait_mask &&
    wait_fields.hold_delay == 2'h0)
    else $error("wait control reset value wrong");
  AST_RESERVED_ZERO: assert property ($rose(pready) && $past(paddr) == `WAIT_CONTROL_OFFSET
    |-> prdata[31:13] == 19'h0 && prdata[5:2] == 4'h0)
    else $error("reserved wait control bits not zero");
  AST_SETUP_DELAY: assert property ($rose(strobe_on) && !chip_select_n
    |-> phase_len == {5'h0, cur_fields.setup_delay, 1'b1})
    else $error("setup delay length wrong");
  AST_HOLD_DELAY: assert property ($rose(chip_select_n)
    |-> phase_len == {5'h0, cur_fields.hold_delay, 1'b1})
    else $error("hold delay length wrong");
  AST_MASKED_STROBE: assert property ($fell(strobe_on) && cur_fields.external_wait_mask
    |-> phase_len == {1'b0, strobe_len})
    else $error("masked strobe length wrong");
  AST_WAIT_18: assert property ($fell(strobe_on) && cur_fields.external_wait_mask &&
    cur_fields.access_wait == 4'hB |-> phase_len == 8'h26)
    else $error("code 1011 strobe length wrong");
  AST_WAIT_STRETCH: assert property (state == area_wait_pkg::ST_STROBE && cnt == 7'h00 &&
    clk_en && wait_honoured |=> strobe_on ##0 state == area_wait_pkg::ST_STROBE)
    else $error("honoured wait did not stretch strobe");
  AST_ZERO_WAIT_MASK: assert property (state == area_wait_pkg::ST_STROBE && cnt == 7'h00 &&
    clk_en && !external_wait_n && cur_fields.external_wait_mask |=> !strobe_on)
    else $error("mask ignored at zero wait");
  AST_TYPE_REFUSE: assert property (state == area_wait_pkg::ST_IDLE && clk_en &&
    mem_req_valid && mem_req_ready && !type_ok |=> mem_done && mem_error && chip_select_n)
    else $error("bad memory type not refused");

endmodule
`default_nettype wire

//--- hw/wait_timing_decode.sv
// Turns the wait control fields into phase lengths in reference ticks.
// Assumes one reference tick is half a bus cycle.
`timescale 1ns/1ps
`default_nettype none
`include "area_wait_defines.svh"

module wait_timing_decode (
  input  wire area_wait_pkg::wait_fields_t fields,
  output logic [6:0]                       setup_len,
  output logic [6:0]                       strobe_len,
  output logic [6:0]                       hold_len
);

  logic [6:0] wait_cycles;

  // Access wait code to whole bus cycles
  always_comb begin
    case (fields.access_wait)
      4'h7:    wait_cycles = 7'h08;
      4'h8:    wait_cycles = 7'h0A;
      4'h9:    wait_cycles = 7'h0C;
      4'hA:    wait_cycles = 7'h0E;
      4'hB:    wait_cycles = 7'h12;
      4'hC:    wait_cycles = 7'h18;
      // Reserved codes: longest legal wait, the safe side for slow parts
      4'hD,
      4'hE,
      4'hF:    wait_cycles = 7'h18;
      default: wait_cycles = {3'h0, fields.access_wait};
    endcase
  end

  // Half-cycle delays: code n gives n + 0.5 bus cycles
  assign setup_len  = {4'h0, fields.setup_delay, 1'b1};
  assign hold_len   = {4'h0, fields.hold_delay, 1'b1};
  // Strobe lasts one base cycle plus the wait cycles
  assign strobe_len = 7'((wait_cycles + 7'h01) * `TICKS_PER_BUS_CYCLE);

endmodule
`default_nettype wire

//--- testbench/sram_model.sv
// Behavioural asynchronous memory on the far side of the wait controller.
// Assumes the controller's ref_clk and a 256-word array indexed by mem_addr.
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  input  wire logic        ref_clk,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic [1:0]  byte_enable_n,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  input  wire logic [31:0] wait_ticks,
  output logic      [15:0] data_in,
  output logic             external_wait_n
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  int          cnt  = 0;

  // Lanes land while selected, driven and strobed
  always @(posedge ref_clk) begin
    if (!chip_select_n && !data_oe_n) begin
      if (!byte_enable_n[0]) mem[mem_addr[7:0]][7:0] <= data_out[7:0];
      if (!byte_enable_n[1]) mem[mem_addr[7:0]][15:8] <= data_out[15:8];
    end
  end

  // Strobe tick counter; last value kept to invert it once released
  always @(posedge ref_clk) begin
    if (!read_n) last <= data_in;
    cnt <= read_n ? 0 : cnt + 1;
  end

  // Released bus shows inverted data so a stale copy cannot pass
  assign data_in = (!chip_select_n && !read_n) ? mem[mem_addr[7:0]] : ~last;
  // Wait held low for the first wait_ticks strobe ticks
  assign external_wait_n = !(!read_n && cnt < wait_ticks);
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench: APB register tasks and timed memory accesses.
// Assumes the constants header and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "area_wait_defines.svh"
module testbench;
  localparam logic [7:0] bus_ctl  = `BUS_CONTROL_OFFSET;
  localparam logic [7:0] wait_ctl = `WAIT_CONTROL_OFFSET;
  localparam logic [7:0] status   = `STATUS_OFFSET;
  logic                    ref_clk, rst_n, clk_en, psel, penable, pwrite, err;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    pready, pslverr, mem_req_valid, mem_req_ready;
  logic                    mem_done, mem_error, chip_select_n, read_n;
  logic                    data_oe_n, external_wait_n;
  logic [1:0]              byte_enable_n;
  logic [15:0]             mem_rdata, mem_addr, data_out, data_in;
  area_wait_pkg::mem_req_t mem_req;
  int                      failures, compares, wait_ticks, su, st, ho;
  int                      wait_cyc [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

  area_wait_ctrl area_wait_ctrl_inst (.ref_clk, .rst_n, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req_valid, .mem_req,
    .mem_req_ready, .mem_done, .mem_error, .mem_rdata, .mem_addr, .chip_select_n,
    .read_n, .byte_enable_n, .data_out, .data_oe_n, .data_in, .external_wait_n);
  sram_model sram_model_inst (.ref_clk, .chip_select_n, .read_n, .byte_enable_n,
    .mem_addr, .data_out, .data_oe_n, .wait_ticks, .data_in, .external_wait_n);

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One memory access; counts setup, strobe and hold ticks up to done
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
    su = 0;
    st = 0;
    ho = 0;
    @(posedge ref_clk);
    mem_req_valid <= 1'b1;
    mem_req <= '{wr, 2'b11, a, d};
    do @(posedge ref_clk); while (mem_req_ready !== 1'b1);
    mem_req_valid <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      @(posedge ref_clk);
      if (mem_done === 1'b1) begin
        err = mem_error;
        break;
      end
      if (!read_n || byte_enable_n != 2'b11) st++;
      else if (!chip_select_n && st == 0) su++;
      else if (!chip_select_n) ho++;
      // An access that never ends is a mismatch, not a silent pass
      if (n == 299) begin
        failures++;
        $display("mismatch at %0t: mem_done got %h expected %h", $time, mem_done, 1'b1);
      end
    end
  endtask

  // Hang guard, well beyond the several hundred cycles the tests need
  initial begin
    #500_000;
    failures++;
    print_verdict;
  end

  initial begin
    {rst_n, psel, penable, pwrite, mem_req_valid} = '0;
    {paddr, pwdata, mem_req} = '0;
    {failures, compares, wait_ticks} = '0;
    clk_en = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(0, wait_ctl, 0);
    check(rd, 32'h0000_0500);
    apb(0, bus_ctl, 0);
    check(rd, 32'h0000_0000);
    apb(0, 8'h0C, 0);
    check({rd[30:0], err}, 32'h0000_0001);
    $display("test reset values done");
    // Ones in reserved bits must read back as zero
    apb(1, bus_ctl, 32'h0000_0000);
    apb(1, wait_ctl, 32'hFFFF_F87F);
    apb(0, wait_ctl, 0);
    check(rd, 32'h0000_1843);
    $display("test reserved bits done");
    for (int s = 0; s < 4; s++) begin
      apb(1, wait_ctl, (s << 11) | 32'h40 | (3 - s));
      access(0, 16'h0010, 16'h0000);
      check(su, 2 * s + 1);
      check(ho, 7 - 2 * s);
    end
    $display("test setup and hold done");
    // Every legal wait code, reads and writes alternating; reserved codes never written
    for (int w = 0; w < 13; w++) begin
      apb(1, wait_ctl, (w << 7) | 32'h40);
      access(w[0], 16'h0020, 16'h1234);
      check(st, 2 * wait_cyc[w] + 2);
    end
    $display("test wait codes done");
    wait_ticks <= 5;
    apb(1, wait_ctl, 32'h0000_0000);
    access(0, 16'h0010, 16'h0000);
    check(st, 6);
    apb(1, wait_ctl, 32'h0000_0040);
    access(0, 16'h0010, 16'h0000);
    check(st, 2);
    wait_ticks <= 0;
    $display("test external wait done");
    // Three frozen ticks inside a 10-tick strobe stretch it to 13
    apb(1, wait_ctl, 32'h0000_0240);
    fork
      access(0, 16'h0010, 16'h0000);
      begin
        repeat (4) @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join
    check(st, 13);
    $display("test clock enable done");
    // Type first, then timing, before any access
    apb(1, bus_ctl, 32'h0000_3000);
    apb(1, wait_ctl, 32'h0000_0040);
    access(1, 16'h0030, 16'hA5C3);
    access(0, 16'h0030, 16'h0000);
    check({16'h0000, mem_rdata}, 32'h0000_A5C3);
    $display("test byte select sram done");
    // Unsupported memory type refused without pin activity
    apb(1, bus_ctl, 32'h0000_5000);
    apb(1, wait_ctl, 32'h0000_0040);
    access(0, 16'h0010, 16'h0000);
    check(su + st + ho, 0);
    check({31'h0, err}, 32'h0000_0001);
    apb(0, status, 0);
    check(rd, 32'h0000_0002);
    apb(1, bus_ctl, 32'h0000_0000);
    apb(1, wait_ctl, 32'h0000_0040);
    access(0, 16'h0010, 16'h0000);
    check({31'h0, err}, 32'h0000_0000);
    $display("test memory type done");
    print_verdict;
  end
endmodule
`default_nettype wire
